// ==== sps_regs.vh ====
// Constants shared by the setpoint program sequencer files.
// Assumes values are signed tenths of a unit and times are tenths of a minute.
`ifndef SPS_REGS_VH
`define SPS_REGS_VH

// ==========================================
// Run states
`define SPS_RUN_OFF 2'h0
`define SPS_RUN_ON 2'h1
`define SPS_RUN_STOP 2'h2

// ==========================================
// Factory defaults and limits
`define SPS_DEV_DEFAULT 16'h0032
`define SPS_CYCLE_DEFAULT 8'h01
`define SPS_CYCLE_ENDLESS 8'h00
`define SPS_TIME_MAX 14'h270F
`define SPS_TIME_ZERO 14'h0000
`define SPS_ASSIGN_STATUS 5'h00
`define SPS_STEPS_OFF 5'h00

// ==========================================
// Step word fields
`define SPS_WORD_TARGET 29:14
`define SPS_WORD_TIME 13:0

// ==========================================
// Timing
`define SPS_TICK_MS 6000
`define SPS_CLK_NS 50
`define SPS_NS_PER_MS 1000000

`endif

// ==== sps_prog_mem.v ====
// Program step store: one word per program and step.
// Assumes a single clock; read data appear one edge after the read.
`timescale 1ns/1ps
module sps_prog_mem #(
    parameter DW = 30,
    parameter DEPTH = 80,
    parameter AW = 7
) (
    input wire i_clk,
    input wire i_wr_en,
    input wire [AW-1:0] i_wr_addr,
    input wire [DW-1:0] i_wr_data,
    input wire i_rd_en,
    input wire [AW-1:0] i_rd_addr,
    output reg [DW-1:0] o_rd_data_q
);

    reg [DW-1:0] mem [0:DEPTH-1];

    // No reset: contents must be loaded before a program runs
    always @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        if (i_rd_en) begin
            o_rd_data_q <= mem[i_rd_addr];
        end
    end

endmodule

// ==== sps_aux_relay.v ====
// One auxiliary relay driver with selectable source and polarity.
// Assumes step numbers are zero based at its input.
`timescale 1ns/1ps
`include "sps_regs.vh"
module sps_aux_relay (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_prog_active,
    input wire i_step_active,
    input wire [4:0] i_step,
    input wire [4:0] i_assign,
    input wire i_invert,
    output reg o_relay_q
);

    wire cond;

    // Status assignment or exact step match, steps counted from one
    assign cond = (i_assign == `SPS_ASSIGN_STATUS) ? i_prog_active :
                  (i_step_active && (i_assign == (i_step + 5'h01)));

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_relay_q <= 1'b0;
        end else begin
            o_relay_q <= cond ^ i_invert;
        end
    end

endmodule

// ==== sps_sequencer.v ====
// Setpoint program sequencer top: stored programs, ramp engine, run control.
// Assumes all inputs synchronous to I_CORE_CLK and config strobes one cycle long.
`timescale 1ns/1ps
`include "sps_regs.vh"
module sps_sequencer #(
    parameter NUM_PROGS = 4,
    parameter MAX_STEPS = 20,
    parameter NUM_RELAYS = 2,
    parameter TICK_CYCLES = `SPS_TICK_MS * (`SPS_NS_PER_MS / `SPS_CLK_NS),
    parameter TW = 27
) (
    input wire I_CORE_CLK,
    input wire I_ARST_N,
    input wire I_CMD_START,
    input wire I_CMD_STOP,
    input wire I_CMD_ABORT,
    input wire I_START_CONTACT,
    input wire [3:0] I_PROG_START,
    input wire [2:0] I_PROG_SELECT,
    input wire I_STEP_COUNT_WR,
    input wire [4:0] I_STEP_COUNT,
    input wire I_CYCLE_COUNT_WR,
    input wire [7:0] I_CYCLE_COUNT,
    input wire I_DEV_LIMIT_WR,
    input wire [15:0] I_DEV_LIMIT,
    input wire [15:0] I_BASIC_SETPOINT,
    input wire [15:0] I_ACTUAL_VALUE,
    input wire I_STEP_WR,
    input wire [2:0] I_STEP_WR_PROG,
    input wire [4:0] I_STEP_WR_IDX,
    input wire [15:0] I_STEP_WR_TARGET,
    input wire [13:0] I_STEP_WR_TIME,
    input wire [NUM_RELAYS*5-1:0] I_RELAY_ASSIGN,
    input wire [NUM_RELAYS-1:0] I_RELAY_INVERT,
    output reg [15:0] O_SETPOINT,
    output reg [1:0] O_RUN_STATE,
    output reg [4:0] O_STEP,
    output reg [7:0] O_CYCLES_LEFT,
    output reg [2:0] O_ACTIVE_PROG,
    output reg O_PAUSED,
    output reg O_PROG_ENABLED,
    output wire [NUM_RELAYS-1:0] O_RELAY
);

    // ==========================================
    // Sizes and sequencer states
    localparam DEPTH = NUM_PROGS * MAX_STEPS;
    localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam DW = 30;
    localparam [4:0] STEPS_MAX = MAX_STEPS;
    localparam [2:0] PROG_LAST = NUM_PROGS - 1;
    localparam [TW-1:0] TICK_LAST = TICK_CYCLES - 1;
    localparam [1:0] SQ_IDLE = 2'b00;
    localparam [1:0] SQ_FETCH = 2'b01;
    localparam [1:0] SQ_LOAD = 2'b10;
    localparam [1:0] SQ_EXEC = 2'b11;

    // Flat memory index of one program step
    function [AW-1:0] step_addr;
        input [2:0] prog;
        input [4:0] step;
        reg [31:0] t;
        begin
            t = prog * MAX_STEPS + step;
            step_addr = t[AW-1:0];
        end
    endfunction

    // ==========================================
    // Reset release
    reg rst_meta_q;
    reg rst_sync_q;
    wire rst_n;

    always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rst_n = rst_sync_q;

    // ==========================================
    // Configuration registers
    reg [4:0] step_count_q;
    reg [7:0] cycle_cfg_q;
    reg [15:0] dev_limit_q;

    always @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            step_count_q <= STEPS_MAX;
            cycle_cfg_q <= `SPS_CYCLE_DEFAULT;
            dev_limit_q <= `SPS_DEV_DEFAULT;
        end else begin
            if (I_STEP_COUNT_WR) begin
                // Clamp to the capacity of this build
                step_count_q <= (I_STEP_COUNT > STEPS_MAX) ? STEPS_MAX : I_STEP_COUNT;
            end
            if (I_CYCLE_COUNT_WR) begin
                cycle_cfg_q <= I_CYCLE_COUNT;
            end
            if (I_DEV_LIMIT_WR) begin
                dev_limit_q <= I_DEV_LIMIT;
            end
        end
    end

    // ==========================================
    // Step store
    wire [13:0] wr_time;
    wire [DW-1:0] rd_data;
    wire [15:0] rd_target;
    wire [13:0] rd_time;
    reg rd_en;

    assign wr_time = (I_STEP_WR_TIME > `SPS_TIME_MAX) ? `SPS_TIME_MAX : I_STEP_WR_TIME;
    assign rd_target = rd_data[`SPS_WORD_TARGET];
    assign rd_time = rd_data[`SPS_WORD_TIME];

    // ==========================================
    // Start sources
    reg contact_prev_q;
    reg [3:0] prog_start_prev_q;
    wire contact_edge;
    wire [3:0] prog_edge;
    wire any_start;
    reg [2:0] edge_prog;

    assign contact_edge = I_START_CONTACT && !contact_prev_q;
    assign prog_edge = I_PROG_START & ~prog_start_prev_q;
    assign any_start = I_CMD_START || contact_edge || (prog_edge != 4'h0);

    // Lowest numbered input wins if several close together
    always @* begin
        edge_prog = 3'h0;
        if (prog_edge[0]) begin
            edge_prog = 3'h0;
        end else if (prog_edge[1]) begin
            edge_prog = 3'h1;
        end else if (prog_edge[2]) begin
            edge_prog = 3'h2;
        end else if (prog_edge[3]) begin
            edge_prog = 3'h3;
        end
    end

    always @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            contact_prev_q <= 1'b0;
            prog_start_prev_q <= 4'h0;
        end else begin
            contact_prev_q <= I_START_CONTACT;
            prog_start_prev_q <= I_PROG_START;
        end
    end

    // ==========================================
    // Sequencer state
    reg [1:0] run_q;
    reg [1:0] seq_q;
    reg [2:0] prog_q;
    reg [4:0] step_q;
    reg [7:0] cycles_left_q;
    reg [15:0] sp_q;
    reg [15:0] target_q;
    reg [13:0] rem_q;
    reg [TW-1:0] tick_q;

    // Deviation between actual value and running setpoint
    wire signed [16:0] dev_w;
    wire [16:0] dev_abs;
    wire deviating;

    assign dev_w = $signed({I_ACTUAL_VALUE[15], I_ACTUAL_VALUE}) - $signed({sp_q[15], sp_q});
    assign dev_abs = dev_w[16] ? (17'h00000 - dev_w) : dev_w;
    assign deviating = dev_abs > {1'b0, dev_limit_q};

    // Ramp increment: remaining difference over remaining ticks
    wire signed [17:0] diff_w;
    wire signed [17:0] divisor_w;
    wire signed [17:0] quot_w;
    wire [15:0] sp_ramp;

    assign diff_w = $signed({target_q[15], target_q[15], target_q}) - $signed({sp_q[15], sp_q[15], sp_q});
    // Divisor never zero; rem_q is zero only outside the ramp branch
    assign divisor_w = {4'h0, ((rem_q == `SPS_TIME_ZERO) ? 14'h0001 : rem_q)};
    assign quot_w = diff_w / divisor_w;
    assign sp_ramp = sp_q + quot_w[15:0];

    wire prog_enabled;
    wire last_step;
    wire tick_done;

    assign prog_enabled = step_count_q != `SPS_STEPS_OFF;
    assign last_step = (step_q + 5'h01) >= step_count_q;
    assign tick_done = tick_q == TICK_LAST;

    always @* begin
        rd_en = (seq_q == SQ_FETCH) && (run_q == `SPS_RUN_ON);
    end

    always @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= `SPS_RUN_OFF;
            seq_q <= SQ_IDLE;
            prog_q <= 3'h0;
            step_q <= 5'h00;
            cycles_left_q <= 8'h00;
            sp_q <= 16'h0000;
            target_q <= 16'h0000;
            rem_q <= `SPS_TIME_ZERO;
            tick_q <= {TW{1'b0}};
        end else if (I_CMD_ABORT || !prog_enabled) begin
            // Abort ends the program; a disabled function cannot run at all
            run_q <= `SPS_RUN_OFF;
            seq_q <= SQ_IDLE;
            step_q <= 5'h00;
            sp_q <= I_BASIC_SETPOINT;
        end else if (I_CMD_STOP && (run_q == `SPS_RUN_ON)) begin
            run_q <= `SPS_RUN_STOP;
        end else if (any_start && (run_q == `SPS_RUN_STOP)) begin
            run_q <= `SPS_RUN_ON;
        end else if (run_q == `SPS_RUN_OFF) begin
            sp_q <= I_BASIC_SETPOINT;
            if (prog_edge != 4'h0 && edge_prog <= PROG_LAST) begin
                prog_q <= edge_prog;
            end else if (I_PROG_SELECT <= PROG_LAST) begin
                prog_q <= I_PROG_SELECT;
            end
            if (any_start) begin
                run_q <= `SPS_RUN_ON;
                seq_q <= SQ_FETCH;
                step_q <= 5'h00;
                cycles_left_q <= cycle_cfg_q;
            end
        end else if (run_q == `SPS_RUN_ON) begin
            case (seq_q)
                SQ_FETCH: begin
                    seq_q <= SQ_LOAD;
                end
                SQ_LOAD: begin
                    target_q <= rd_target;
                    rem_q <= rd_time;
                    tick_q <= {TW{1'b0}};
                    if (rd_time != `SPS_TIME_ZERO) begin
                        seq_q <= SQ_EXEC;
                    end else if (rd_target != sp_q) begin
                        sp_q <= rd_target;
                        seq_q <= SQ_EXEC;
                    end else begin
                        // Unused step: move on at once
                        seq_q <= SQ_IDLE;
                    end
                end
                SQ_EXEC: begin
                    if (deviating) begin
                        // Frozen: no ramp step, no time elapses
                        tick_q <= tick_q;
                    end else if (rem_q == `SPS_TIME_ZERO) begin
                        seq_q <= SQ_IDLE;
                    end else if (tick_done) begin
                        tick_q <= {TW{1'b0}};
                        rem_q <= rem_q - 14'h0001;
                        // Quotient truncates; the last tick
                        // divides by one and lands on the target
                        sp_q <= sp_ramp;
                    end else begin
                        tick_q <= tick_q + {{(TW-1){1'b0}}, 1'b1};
                    end
                end
                default: begin
                    // Step finished: next step, next cycle or end
                    seq_q <= SQ_FETCH;
                    if (!last_step) begin
                        step_q <= step_q + 5'h01;
                    end else if (cycle_cfg_q == `SPS_CYCLE_ENDLESS) begin
                        step_q <= 5'h00;
                    end else if (cycles_left_q > 8'h01) begin
                        step_q <= 5'h00;
                        cycles_left_q <= cycles_left_q - 8'h01;
                    end else begin
                        cycles_left_q <= 8'h00;
                        run_q <= `SPS_RUN_OFF;
                        seq_q <= SQ_IDLE;
                        step_q <= 5'h00;
                        sp_q <= I_BASIC_SETPOINT;
                    end
                end
            endcase
        end
    end

    sps_prog_mem #(
        .DW(DW),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .i_clk(I_CORE_CLK),
        .i_wr_en(I_STEP_WR && (I_STEP_WR_PROG <= PROG_LAST) && (I_STEP_WR_IDX < STEPS_MAX)),
        .i_wr_addr(step_addr(I_STEP_WR_PROG, I_STEP_WR_IDX)),
        .i_wr_data({I_STEP_WR_TARGET, wr_time}),
        .i_rd_en(rd_en),
        .i_rd_addr(step_addr(prog_q, step_q)),
        .o_rd_data_q(rd_data)
    );

    // ==========================================
    // Outputs
    always @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_SETPOINT <= 16'h0000;
            O_RUN_STATE <= `SPS_RUN_OFF;
            O_STEP <= 5'h00;
            O_CYCLES_LEFT <= 8'h00;
            O_ACTIVE_PROG <= 3'h0;
            O_PAUSED <= 1'b0;
            O_PROG_ENABLED <= 1'b0;
        end else begin
            O_SETPOINT <= (run_q == `SPS_RUN_OFF) ? I_BASIC_SETPOINT : sp_q;
            O_RUN_STATE <= run_q;
            O_STEP <= step_q;
            O_CYCLES_LEFT <= cycles_left_q;
            O_ACTIVE_PROG <= prog_q;
            O_PAUSED <= (run_q == `SPS_RUN_ON) && (seq_q == SQ_EXEC) && deviating;
            O_PROG_ENABLED <= prog_enabled;
        end
    end

    // ==========================================
    // Auxiliary relays
    genvar gi;
    generate
        for (gi = 0; gi < NUM_RELAYS; gi = gi + 1) begin : g_relay
            sps_aux_relay u_relay (
                .i_clk(I_CORE_CLK),
                .i_rst_n(rst_n),
                .i_prog_active(run_q != `SPS_RUN_OFF),
                .i_step_active((run_q != `SPS_RUN_OFF) && (seq_q == SQ_EXEC)),
                .i_step(step_q),
                .i_assign(I_RELAY_ASSIGN[gi*5 +: 5]),
                .i_invert(I_RELAY_INVERT[gi]),
                .o_relay_q(O_RELAY[gi])
            );
        end
    endgenerate

endmodule

// ==== sps_seq_assertions.sv ====
// Port-level checks on the setpoint program sequencer top.
// Assumes a bind from the bench and stable basic setpoint while off.
`timescale 1ns/1ps
`include "sps_regs.vh"
module sps_seq_assertions #(
    parameter NUM_RELAYS = 2
) (
    input wire I_CORE_CLK,
    input wire I_ARST_N,
    input wire I_CMD_START,
    input wire I_CMD_STOP,
    input wire I_CMD_ABORT,
    input wire I_START_CONTACT,
    input wire I_STEP_COUNT_WR,
    input wire [4:0] I_STEP_COUNT,
    input wire [15:0] I_BASIC_SETPOINT,
    input wire [NUM_RELAYS*5-1:0] I_RELAY_ASSIGN,
    input wire [NUM_RELAYS-1:0] I_RELAY_INVERT,
    input wire [15:0] O_SETPOINT,
    input wire [1:0] O_RUN_STATE,
    input wire O_PAUSED,
    input wire O_PROG_ENABLED,
    input wire [NUM_RELAYS-1:0] O_RELAY
);
    // ==========================================
    // Settle counter: outputs lag reset release by the synchroniser
    reg [2:0] up_q;
    wire settled = (up_q == 3'h7);
    always @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            up_q <= 3'h0;
        end else if (!settled) begin
            up_q <= up_q + 3'h1;
        end
    end

    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_ARST_N);

    sequence s_off3;
        (O_RUN_STATE == `SPS_RUN_OFF)[*3];
    endsequence
    sequence s_stop2;
        (O_RUN_STATE == `SPS_RUN_STOP)[*2];
    endsequence

    // ==========================================
    // Checks
    chk_off_basic: assert property (s_off3 ##0 (settled && $stable(I_BASIC_SETPOINT))
        |-> O_SETPOINT == I_BASIC_SETPOINT) else $error("setpoint not basic while off");
    chk_disabled_off: assert property ((!O_PROG_ENABLED)[*3] |-> O_RUN_STATE == `SPS_RUN_OFF)
        else $error("program runs while disabled");
    chk_count_zero: assert property (I_STEP_COUNT_WR && I_STEP_COUNT == 5'h00 |-> ##[1:3] !O_PROG_ENABLED)
        else $error("step count zero did not disable");
    chk_start_run: assert property (settled && O_RUN_STATE == `SPS_RUN_OFF && O_PROG_ENABLED && I_CMD_START
        && !I_CMD_STOP && !I_CMD_ABORT |-> ##2 O_RUN_STATE == `SPS_RUN_ON) else $error("start not taken");
    chk_abort_off: assert property (I_CMD_ABORT |-> ##2 O_RUN_STATE == `SPS_RUN_OFF)
        else $error("abort not taken");
    chk_stop_run: assert property (O_RUN_STATE == `SPS_RUN_ON && I_CMD_STOP && !I_CMD_ABORT
        |-> ##2 O_RUN_STATE == `SPS_RUN_STOP) else $error("stop not taken");
    chk_stop_hold: assert property (s_stop2 |-> $stable(O_SETPOINT))
        else $error("setpoint moved while stopped");
    chk_pause_hold: assert property (O_PAUSED[*3] |-> $stable(O_SETPOINT))
        else $error("setpoint moved while paused");
    chk_contact_go: assert property (settled && $rose(I_START_CONTACT) && O_RUN_STATE == `SPS_RUN_OFF
        && O_PROG_ENABLED && !I_CMD_ABORT |-> ##[1:4] O_RUN_STATE == `SPS_RUN_ON) else $error("contact start lost");
    chk_relay_status: assert property (settled && I_RELAY_ASSIGN[4:0] == 5'h00 && $stable(I_RELAY_INVERT[0])
        && O_RUN_STATE == $past(O_RUN_STATE) && O_RUN_STATE == $past(O_RUN_STATE, 2)
        && O_RUN_STATE != `SPS_RUN_STOP |-> O_RELAY[0] == ((O_RUN_STATE == `SPS_RUN_ON) ^ I_RELAY_INVERT[0]))
        else $error("status relay wrong");
endmodule

// ==== sps_plant_model.sv ====
// Control loop stand-in: actual value tracks the setpoint.
// Assumes the bench raises i_hold to make the process lag.
`timescale 1ns/1ps
module sps_plant_model (
    input wire i_clk,
    input wire i_hold,
    input wire [15:0] i_setpoint,
    output reg [15:0] o_actual
);
    // Follows one cycle late; frozen while held so the monitor trips
    initial o_actual = 16'h0000;
    always @(posedge i_clk) begin
        if (!i_hold) begin
            o_actual <= i_setpoint;
        end
    end
endmodule

// ==== sps_tb.sv ====
// Self-checking bench for the setpoint program sequencer.
// Assumes a tick of 4 cycles and the tracking plant model.
`timescale 1ns/1ps
`include "sps_regs.vh"
module tb;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg start = 1'b0;
    reg stop_c = 1'b0;
    reg abort_c = 1'b0;
    reg contact = 1'b0;
    reg hold = 1'b0;
    reg [3:0] pstart = 4'h0;
    reg [2:0] psel = 3'h0;
    reg cwr = 1'b0;
    reg [4:0] cnt = 5'h00;
    reg ywr = 1'b0;
    reg [7:0] cyc = 8'h00;
    reg swr = 1'b0;
    reg [4:0] sidx = 5'h00;
    reg [15:0] stgt = 16'h0000;
    reg [13:0] stime = 14'h0000;
    reg dlwr = 1'b0;
    reg [15:0] dlim = 16'h0000;
    reg [15:0] bsp = 16'h00C8;
    reg [2:0] sprog = 3'h0;
    reg [9:0] rasg = 10'h060;
    reg [1:0] rinv = 2'h2;
    wire [15:0] sp, act;
    wire [1:0] rs, relay;
    wire [4:0] step;
    wire [7:0] cyl;
    wire [2:0] ap;
    wire paused, en;
    integer errors = 0;
    integer n_tests = 0;
    integer ncyc = 0;

    initial begin
        forever #25 clk = ~clk;
    end

    sps_sequencer #(.NUM_PROGS(4), .MAX_STEPS(20), .NUM_RELAYS(2), .TICK_CYCLES(4)) dut_u (
        .I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_CMD_START(start), .I_CMD_STOP(stop_c),
        .I_CMD_ABORT(abort_c), .I_START_CONTACT(contact), .I_PROG_START(pstart), .I_PROG_SELECT(psel),
        .I_STEP_COUNT_WR(cwr), .I_STEP_COUNT(cnt), .I_CYCLE_COUNT_WR(ywr), .I_CYCLE_COUNT(cyc),
        .I_DEV_LIMIT_WR(dlwr), .I_DEV_LIMIT(dlim), .I_BASIC_SETPOINT(bsp), .I_ACTUAL_VALUE(act),
        .I_STEP_WR(swr), .I_STEP_WR_PROG(sprog), .I_STEP_WR_IDX(sidx), .I_STEP_WR_TARGET(stgt),
        .I_STEP_WR_TIME(stime), .I_RELAY_ASSIGN(rasg), .I_RELAY_INVERT(rinv), .O_SETPOINT(sp),
        .O_RUN_STATE(rs), .O_STEP(step), .O_CYCLES_LEFT(cyl), .O_ACTIVE_PROG(ap), .O_PAUSED(paused),
        .O_PROG_ENABLED(en), .O_RELAY(relay));

    sps_plant_model plant_u (.i_clk(clk), .i_hold(hold), .i_setpoint(sp), .o_actual(act));

    // ==========================================
    // Tasks
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, errors);
            if (errors == 0 && n_tests > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask

    task check(input string name, input [15:0] seen, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("mismatch %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    function [15:0] cur(input integer w);
        case (w)
            0: cur = {14'h0000, rs};
            1: cur = sp;
            2: cur = {11'h000, step};
            3: cur = {8'h00, cyl};
            4: cur = {15'h0000, paused};
            5: cur = {13'h0000, ap};
            6: cur = {14'h0000, relay};
            default: cur = {15'h0000, en};
        endcase
    endfunction

    // Bounded wait, then compare; first look is just off the edge
    task wait_on(input integer w, input [15:0] e, input integer lim);
        integer i;
        begin
            #1;
            i = 0;
            while (cur(w) !== e && i < lim) begin
                @(posedge clk);
                #1;
                i = i + 1;
            end
            check($sformatf("watch%0d", w), cur(w), e);
        end
    endtask

    task idle(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask

    // k: 0 start, 1 stop, 2 abort, 3 step count, 4 cycle count, 5 deviation limit
    task cmd(input integer k, input [15:0] v);
        begin
            @(posedge clk);
            start <= (k == 0);
            stop_c <= (k == 1);
            abort_c <= (k == 2);
            cwr <= (k == 3);
            cnt <= v[4:0];
            ywr <= (k == 4);
            cyc <= v[7:0];
            dlwr <= (k == 5);
            dlim <= v;
            @(posedge clk);
            {start, stop_c, abort_c, cwr, ywr, dlwr} <= 6'h00;
            #1;
        end
    endtask

    task wstep(input [4:0] idx, input [15:0] tgt, input [13:0] t);
        begin
            @(posedge clk);
            swr <= 1'b1;
            sidx <= idx;
            stgt <= tgt;
            stime <= t;
            @(posedge clk);
            swr <= 1'b0;
        end
    endtask

    // Contact closure held three cycles; k below 4 is a program contact
    task closure(input integer k);
        begin
            @(posedge clk);
            if (k < 4) pstart <= 4'h1 << k;
            else contact <= 1'b1;
            repeat (3) @(posedge clk);
            pstart <= 4'h0;
            contact <= 1'b0;
        end
    endtask

    always @(posedge clk) begin
        ncyc <= ncyc + 1;
        if (ncyc == 5000) begin
            errors = errors + 1;
            report_and_stop;
        end
    end

    // ==========================================
    // Sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        idle(4);
        wait_on(0, `SPS_RUN_OFF, 0);
        wait_on(1, 16'h00C8, 0);
        wait_on(7, 16'h0001, 0);
        cmd(3, 8'h04);
        wstep(5'h00, 16'h01F4, 14'h0000);
        wstep(5'h01, 16'h01F4, 14'h0003);
        wstep(5'h02, 16'h0384, 14'h0004);
        wstep(5'h03, 16'h0384, 14'h0000);
        $display("test reset_load done");
        cmd(0, 8'h00);
        wait_on(0, `SPS_RUN_ON, 4);
        wait_on(1, 16'h01F4, 10);
        wait_on(6, 16'h0003, 4);
        wait_on(2, 16'h0001, 20);
        wait_on(1, 16'h01F4, 0);
        wait_on(2, 16'h0002, 30);
        wait_on(1, 16'h01F4, 0);
        wait_on(6, 16'h0001, 4);
        wait_on(1, 16'h02BC, 30);
        wait_on(1, 16'h0384, 30);
        wait_on(0, `SPS_RUN_OFF, 20);
        idle(3);
        wait_on(1, 16'h00C8, 0);
        wait_on(6, 16'h0002, 0);
        $display("test jump_hold_ramp done");
        cmd(0, 8'h00);
        wait_on(1, 16'h0258, 60);
        @(posedge clk);
        hold <= 1'b1;
        wait_on(4, 16'h0001, 20);
        idle(12);
        wait_on(1, 16'h02BC, 0);
        wait_on(4, 16'h0001, 0);
        @(posedge clk);
        hold <= 1'b0;
        wait_on(1, 16'h0384, 40);
        wait_on(0, `SPS_RUN_OFF, 20);
        $display("test deviation_pause done");
        cmd(0, 8'h00);
        wait_on(2, 16'h0002, 40);
        cmd(1, 8'h00);
        wait_on(0, `SPS_RUN_STOP, 4);
        idle(12);
        wait_on(2, 16'h0002, 0);
        cmd(0, 8'h00);
        wait_on(0, `SPS_RUN_ON, 4);
        cmd(2, 8'h00);
        wait_on(0, `SPS_RUN_OFF, 4);
        idle(3);
        wait_on(1, 16'h00C8, 0);
        $display("test stop_resume_abort done");
        cmd(4, 8'h02);
        closure(4);
        wait_on(0, `SPS_RUN_ON, 6);
        wait_on(3, 16'h0002, 0);
        wait_on(3, 16'h0001, 80);
        wait_on(0, `SPS_RUN_ON, 0);
        wait_on(0, `SPS_RUN_OFF, 80);
        $display("test contact_cycles done");
        @(posedge clk);
        psel <= 3'h1;
        wait_on(5, 16'h0001, 4);
        cmd(4, 8'h00);
        closure(0);
        wait_on(0, `SPS_RUN_ON, 6);
        wait_on(5, 16'h0000, 0);
        idle(150);
        wait_on(0, `SPS_RUN_ON, 0);
        wait_on(5, 16'h0000, 0);
        cmd(2, 8'h00);
        wait_on(0, `SPS_RUN_OFF, 4);
        @(posedge clk);
        bsp <= 16'h0064;
        sprog <= 3'h1;
        wait_on(1, 16'h0064, 4);
        wstep(5'h00, 16'h0320, 14'h0002);
        cmd(3, 8'h01);
        cmd(4, 8'h01);
        cmd(5, 16'h03E8);
        @(posedge clk);
        hold <= 1'b1;
        cmd(0, 8'h00);
        wait_on(5, 16'h0001, 4);
        wait_on(1, 16'h0320, 30);
        wait_on(0, `SPS_RUN_OFF, 10);
        @(posedge clk);
        hold <= 1'b0;
        cmd(3, 8'h00);
        wait_on(7, 16'h0000, 4);
        cmd(0, 8'h00);
        idle(4);
        wait_on(0, `SPS_RUN_OFF, 0);
        $display("test select_disable done");
        report_and_stop;
    end
endmodule

bind sps_sequencer sps_seq_assertions #(.NUM_RELAYS(NUM_RELAYS)) chk_u (.I_CORE_CLK, .I_ARST_N, .I_CMD_START,
    .I_CMD_STOP, .I_CMD_ABORT, .I_START_CONTACT, .I_STEP_COUNT_WR, .I_STEP_COUNT, .I_BASIC_SETPOINT,
    .I_RELAY_ASSIGN, .I_RELAY_INVERT, .O_SETPOINT, .O_RUN_STATE, .O_PAUSED, .O_PROG_ENABLED, .O_RELAY);
